//--- verilog/ieee488_listen_handshake.sv
// Purpose: Acceptor (listen) handshake between an IEEE 488 bus and a peripheral's input port.
// Assumes: Bus lines are open drain; an enable output high means this end pulls the line low.
// Notes:   Handshake lines are synchronised first, so responses lag the bus by a few clocks.
`timescale 1ns/1ns

// Summary of operation
// R1: Handshake and decode every byte under ATN.
// R2: ATN released unaddressed: release NRFD and NDAC.
// R3: Own listen address sets addressed_as_listener.
// R4: Bytes under ATN never reach peripheral.
// R5: Data path only when listener and ATN high.
// R6: Listener keeps driving lines after ATN release.
// R7: Data phase NDAC held until byte_captured.
// R8: Phase switch keeps NDAC low, NRFD high.
// R9: Talker flags error if both lines high.
// R10: Talker waits 2 us settling before NRFD.
// R11: Talker lowers DAV after settling, NRFD high.
// R12: Data transceivers receive unless commanded talk.
// R13: Not busy and DAV high: release NRFD.
// R14: Busy peripheral holds NRFD low.
// R15: DAV low: drive NRFD low first.
// R16: DAV low while listener: pulse capture_strobe.
// R17: Peripheral raises byte_captured after latching.
// R18: byte_captured in data phase releases NDAC.
// R19: DAV high returns to ready state.
// R20: Synchronise inputs; NDAC low before NRFD high.
module ieee488_listen_handshake
    import ieee488_pkg::*;
(
    input  logic       clk_in,
    input  logic       rst_in,
    input  logic       ce_in,
    input  logic       atn_n_in,
    input  logic       dav_n_in,
    input  logic       nrfd_n_in,
    output logic       nrfd_n_out,
    output logic       nrfd_oe_out,
    input  logic       ndac_n_in,
    output logic       ndac_n_out,
    output logic       ndac_oe_out,
    input  logic [7:0] bus_data_n_in,
    input  logic [4:0] listen_addr_in,
    input  logic       talk_enable_in,
    output logic       data_receive_out,
    input  logic       peripheral_busy_in,
    input  logic       byte_captured_in,
    output logic       capture_strobe_out,
    output logic [7:0] peripheral_data_out,
    output logic       addressed_as_listener_out,
    output logic       no_listener_error_out
);

    ctl_sync_t  raw_ctl;
    ctl_sync_t  ctl;
    hs_state_t  state_reg;
    hs_state_t  state_next;
    logic       listener_reg;
    logic       listener_next;
    logic [7:0] data_reg;
    logic       data_phase;
    logic       busy_hold;
    logic [6:0] cmd_byte;
    logic       is_own_listen;
    logic       is_unlisten;
    logic       decode_now;
    logic       load_data;

    // Decode helper: a listen-group byte carrying the given address.
    function automatic logic listen_match(input logic [6:0] cmd, input logic [4:0] addr);
        listen_match = (cmd[6:5] == LISTEN_GROUP) && (cmd[4:0] == addr);
    endfunction : listen_match

    // Bus lines are active low; the struct carries them asserted high.
    assign raw_ctl = '{atn: ~atn_n_in, dav: ~dav_n_in, nrfd: ~nrfd_n_in, ndac: ~ndac_n_in,
                       busy: peripheral_busy_in, captured: byte_captured_in};

    ctl_synchroniser u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .raw_in   (raw_ctl),
        .sync_out (ctl)
    ); // [R20]

    // Phase selection and byte decode.
    assign data_phase    = listener_reg & ~ctl.atn;                             // [R5]
    assign busy_hold     = data_phase & ctl.busy;                               // [R14]
    assign cmd_byte      = ~bus_data_n_in[6:0] & CMD_MASK;
    assign is_own_listen = listen_match(cmd_byte, listen_addr_in);              // [R3]
    assign is_unlisten   = listen_match(cmd_byte, UNLISTEN_CODE);
    assign decode_now    = (state_reg == ST_HOLD) & ctl.atn;                    // [R1]
    assign load_data     = (state_reg == ST_READY) & data_phase & ctl.dav & ~busy_hold; // [R4]

    // Next-state logic: ATN or a dropped listener pulls back into the addressing handshake.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (ctl.atn) begin
                    state_next = ST_READY;                                      // [R1]
                end
            end
            ST_READY: begin
                if (!ctl.atn && !listener_reg) begin
                    state_next = ST_IDLE;                                       // [R2]
                end else if (ctl.dav && !busy_hold) begin
                    state_next = ST_HOLD;                                       // [R15]
                end
            end
            ST_HOLD: begin
                if (ctl.atn || ctl.captured || !listener_reg) begin
                    state_next = ST_ACCEPT;                                     // [R7] [R18]
                end
            end
            ST_ACCEPT: begin
                if (!ctl.dav) begin
                    state_next = ST_RECOVER;                                    // [R19]
                end
            end
            ST_RECOVER: begin
                state_next = ST_READY;                                          // [R20]
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Listener flag: set by own listen address, cleared by unlisten, both only under ATN.
    always_comb begin
        listener_next = listener_reg;
        if (decode_now && is_own_listen) begin
            listener_next = 1'b1;                                               // [R3]
        end else if (decode_now && is_unlisten) begin
            listener_next = 1'b0;
        end
    end

    // State, flag and peripheral data register.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg    <= ST_IDLE;
            listener_reg <= 1'b0;
            data_reg     <= 8'h00;
        end else if (ce_in) begin
            state_reg    <= state_next;
            listener_reg <= listener_next;
            if (load_data) begin
                data_reg <= ~bus_data_n_in;                                     // [R4]
            end
        end
    end

    // Line drives. NRFD is pulled in HOLD, ACCEPT and RECOVER; in READY it follows the busy input in the data phase.
    // RECOVER pulls both lines so NDAC is low again before NRFD is released.
    assign nrfd_oe_out = (state_reg == ST_HOLD) | (state_reg == ST_ACCEPT) |
                         (state_reg == ST_RECOVER) | ((state_reg == ST_READY) & busy_hold); // [R13] [R14] [R15]
    assign ndac_oe_out = (state_reg == ST_READY) | (state_reg == ST_HOLD) |
                         (state_reg == ST_RECOVER);                             // [R6] [R7] [R8]
    assign nrfd_n_out  = 1'b0;
    assign ndac_n_out  = 1'b0;

    // Peripheral side: the strobe stands until byte_captured comes back.
    assign capture_strobe_out        = (state_reg == ST_HOLD) & data_phase;     // [R16]
    assign peripheral_data_out       = data_reg;
    assign addressed_as_listener_out = listener_reg;
    assign data_receive_out          = ~talk_enable_in;                         // [R12]
    // Both lines high with ATN released means nobody listens; reported for diagnostics.
    assign no_listener_error_out     = ~ctl.atn & ~ctl.nrfd & ~ctl.ndac & (state_reg == ST_IDLE);

    property p_r2_idle;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_READY && !ctl.atn && !listener_reg) |=> (!nrfd_oe_out && !ndac_oe_out);
    endproperty
    a_r2_idle: assert property (p_r2_idle) else $error("Lines not released after unaddressed ATN end."); // [R2]

    property p_r3_flag;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && decode_now && is_own_listen) |=> addressed_as_listener_out;
    endproperty
    a_r3_flag: assert property (p_r3_flag) else $error("Own listen address did not set listener flag."); // [R3]

    property p_r5_gate;
        @(posedge clk_in) disable iff (rst_in)
        capture_strobe_out |-> (addressed_as_listener_out && !ctl.atn && ctl.dav);
    endproperty
    a_r5_gate: assert property (p_r5_gate) else $error("Capture strobe outside the data phase."); // [R5]

    property p_r7_ndac;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == ST_HOLD && data_phase && !ctl.captured) |-> (ndac_oe_out && nrfd_oe_out);
    endproperty
    a_r7_ndac: assert property (p_r7_ndac) else $error("NDAC released before byte captured."); // [R7]

    property p_r14_busy;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == ST_READY && data_phase) |-> (nrfd_oe_out == ctl.busy) && ndac_oe_out;
    endproperty
    a_r14_busy: assert property (p_r14_busy) else $error("NRFD does not follow peripheral busy."); // [R14]

    property p_r15_first;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_READY && ctl.dav && !busy_hold && (ctl.atn || listener_reg))
            |=> (nrfd_oe_out && ndac_oe_out);
    endproperty
    a_r15_first: assert property (p_r15_first) else $error("NRFD not pulled first on DAV."); // [R15]

    property p_r18_release;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_HOLD && data_phase && ctl.captured) |=> (!ndac_oe_out && nrfd_oe_out);
    endproperty
    a_r18_release: assert property (p_r18_release) else $error("NDAC not released on byte captured."); // [R18]

    property p_r19_ready;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_ACCEPT && !ctl.dav) |=> (ndac_oe_out && nrfd_oe_out);
    endproperty
    a_r19_ready: assert property (p_r19_ready) else $error("No NDAC pull on DAV return."); // [R19]

    property p_r20_order;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg != ST_IDLE) |-> (ndac_oe_out || nrfd_oe_out);
    endproperty
    a_r20_order: assert property (p_r20_order) else $error("Both lines released while handshaking."); // [R20]

    // Addressing handshake: a byte under ATN is acknowledged at once and never reaches the peripheral.
    property p_r1_accept;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_HOLD && ctl.atn) |=> (state_reg == ST_ACCEPT && !ndac_oe_out && nrfd_oe_out);
    endproperty
    a_r1_accept: assert property (p_r1_accept) else $error("Address byte not accepted at once."); // [R1]

    property p_r2_quiet;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == ST_IDLE) |-> (!nrfd_oe_out && !ndac_oe_out && !capture_strobe_out);
    endproperty
    a_r2_quiet: assert property (p_r2_quiet) else $error("Idle state still drives a line."); // [R2]

    property p_r4_frozen;
        @(posedge clk_in) disable iff (rst_in)
        ctl.atn |=> $stable(peripheral_data_out);
    endproperty
    a_r4_frozen: assert property (p_r4_frozen) else $error("Peripheral data changed under ATN."); // [R4]

    property p_r5_atn;
        @(posedge clk_in) disable iff (rst_in)
        ctl.atn |-> !capture_strobe_out;
    endproperty
    a_r5_atn: assert property (p_r5_atn) else $error("Capture strobe raised under ATN."); // [R5]

    // Data phase: the listener keeps the lines and waits on the peripheral.
    property p_r6_drive;
        @(posedge clk_in) disable iff (rst_in)
        addressed_as_listener_out |-> (state_reg != ST_IDLE && (nrfd_oe_out || ndac_oe_out));
    endproperty
    a_r6_drive: assert property (p_r6_drive) else $error("Listener stopped driving the lines."); // [R6]

    property p_r7_wait;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_HOLD && data_phase && !ctl.captured) |=> (state_reg == ST_HOLD);
    endproperty
    a_r7_wait: assert property (p_r7_wait) else $error("Hold left without byte captured."); // [R7]

    property p_r8_switch;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_READY && listener_reg && !ctl.dav) |=> (state_reg == ST_READY && ndac_oe_out);
    endproperty
    a_r8_switch: assert property (p_r8_switch) else $error("Ready state lost at phase switch."); // [R8]

    property p_r13_free;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == ST_READY && data_phase && !ctl.busy) |-> (!nrfd_oe_out && ndac_oe_out);
    endproperty
    a_r13_free: assert property (p_r13_free) else $error("NRFD held while peripheral free."); // [R13]

    property p_r15_keep;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_HOLD) |=> nrfd_oe_out;
    endproperty
    a_r15_keep: assert property (p_r15_keep) else $error("NRFD released during acceptance."); // [R15]

    property p_r16_load;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_READY && data_phase && ctl.dav && !ctl.busy)
            |=> (state_reg == ST_HOLD && peripheral_data_out == ~$past(bus_data_n_in));
    endproperty
    a_r16_load: assert property (p_r16_load) else $error("Strobed byte differs from bus byte."); // [R16]

    // Closing steps: acceptance stands until DAV returns, then recovery leads back to ready.
    property p_r18_keep;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_ACCEPT && ctl.dav) |=> (state_reg == ST_ACCEPT && !ndac_oe_out);
    endproperty
    a_r18_keep: assert property (p_r18_keep) else $error("NDAC pulled again while DAV low."); // [R18]

    property p_r19_back;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_RECOVER) |=> (state_reg == ST_READY && ndac_oe_out);
    endproperty
    a_r19_back: assert property (p_r19_back) else $error("Recovery did not return to ready."); // [R19]

    property p_r20_lag;
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && state_reg == ST_IDLE && !ctl.atn) |=> (state_reg == ST_IDLE);
    endproperty
    a_r20_lag: assert property (p_r20_lag) else $error("Idle left without synchronised ATN."); // [R20]

endmodule : ieee488_listen_handshake

//--- verilog/ieee488_pkg.sv
// Purpose: Shared types and constants for the listen handshake, plus its input synchroniser.
// Assumes: One clock; bus control lines arrive active low and asynchronous to it.
// Notes:   The synchroniser is a plain two-stage chain; only the second stage reads the first.
package ieee488_pkg;

    // Handshake states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_READY   = 5'h02,
        ST_HOLD    = 5'h04,
        ST_ACCEPT  = 5'h08,
        ST_RECOVER = 5'h10
    } hs_state_t;

    // Synchronised control lines, all asserted high.
    typedef struct packed {
        logic atn;
        logic dav;
        logic nrfd;
        logic ndac;
        logic busy;
        logic captured;
    } ctl_sync_t;

    localparam int         CTL_WIDTH     = 6;
    localparam logic [1:0] LISTEN_GROUP  = 2'h1;  // Bits 6:5 of a listen address byte.
    localparam logic [4:0] UNLISTEN_CODE = 5'h1f; // Listen group with all-ones address.
    localparam logic [6:0] CMD_MASK      = 7'h7f; // Bit 7 of a bus byte is not decoded.

endpackage : ieee488_pkg

`timescale 1ns/1ns

// Two-flop synchroniser; the enable freezes both stages together.
module ctl_synchroniser
    import ieee488_pkg::*;
(
    input  logic      clk_in,
    input  logic      rst_in,
    input  logic      ce_in,
    input  ctl_sync_t raw_in,
    output ctl_sync_t sync_out
);

    ctl_sync_t stage1_reg;
    ctl_sync_t stage2_reg;

    // Reset to the released bus state so no false edge appears after reset.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else if (ce_in) begin
            stage1_reg <= raw_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule : ctl_synchroniser

//--- tb/talker_model.sv
// Purpose: Behavioural talker and controller on the bus side of the acceptor.
// Assumes: Handshake and data wires have pull-ups, so released lines read high.
// Notes:   Flags a missing listener and acceptor steps seen out of order.
`timescale 1ns/1ns
module talker_model (
    input  logic       clk_in,
    input  logic       nrfd_wire_in,
    input  logic       ndac_wire_in,
    output logic       atn_n_out,
    output logic       dav_n_out,
    output logic [7:0] data_n_out,
    output logic       absent_out,
    output logic       order_bad_out
);
    localparam int SETTLE = 250; // Two microseconds at 8 ns a cycle.
    // Lines start released.
    initial begin
        {atn_n_out, dav_n_out, data_n_out, absent_out, order_bad_out} = {2'h3, 8'hff, 2'h0};
    end
    // Moves ATN, then gives the acceptor time before judging it.
    task set_atn(input logic on);
        @(negedge clk_in);
        atn_n_out = ~on;
        repeat (8) @(negedge clk_in);
        if (!on) absent_out = nrfd_wire_in & ndac_wire_in;
    endtask : set_atn
    // One source handshake; bounded waits keep a dead acceptor from hanging it.
    task send(input logic [7:0] b);
        int n;
        @(negedge clk_in);
        data_n_out = ~b;
        repeat (SETTLE) @(negedge clk_in);
        if (ndac_wire_in) order_bad_out = 1'b1;
        for (n = 0; n < 4000 && !nrfd_wire_in; n++) @(negedge clk_in);
        dav_n_out = 1'b0;
        for (n = 0; n < 4000 && !ndac_wire_in; n++) @(negedge clk_in);
        if (nrfd_wire_in || !ndac_wire_in) order_bad_out = 1'b1;
        dav_n_out = 1'b1;
        data_n_out = 8'hff;
    endtask : send
endmodule : talker_model

//--- tb/ieee488_listen_handshake_bench.sv
// Purpose: Self-checking bench for the acceptor against a behavioural talker.
// Assumes: Only this acceptor and the model share the wires.
// Notes:   Peripheral latch delay is random, so prompt and slow captures occur.
`timescale 1ns/1ns
module ieee488_listen_handshake_bench;
    import ieee488_pkg::*;
    logic       clk_in, rst_in, talk_in, busy_in, got_in, atn_n, dav_n, nrfd_n, nrfd_oe;
    logic       ndac_n, ndac_oe, rx, strobe, lsn, diag, absent, bad, nrfd_w, ndac_w, ce;
    logic [4:0] addr;
    logic [7:0] data_n, pdata, exp_byte;
    int         seed = 50966, num_errors = 0, checks = 0, cycles = 0, grabs = 0, i;
    // Open-drain wires sit high unless this end pulls.
    assign nrfd_w = nrfd_oe ? nrfd_n : 1'b1;
    assign ndac_w = ndac_oe ? ndac_n : 1'b1;
    ieee488_listen_handshake dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
        .atn_n_in(atn_n), .dav_n_in(dav_n), .nrfd_n_in(nrfd_w), .nrfd_n_out(nrfd_n),
        .nrfd_oe_out(nrfd_oe), .ndac_n_in(ndac_w), .ndac_n_out(ndac_n), .ndac_oe_out(ndac_oe),
        .bus_data_n_in(data_n), .listen_addr_in(addr), .talk_enable_in(talk_in),
        .data_receive_out(rx), .peripheral_busy_in(busy_in), .byte_captured_in(got_in),
        .capture_strobe_out(strobe), .peripheral_data_out(pdata),
        .addressed_as_listener_out(lsn), .no_listener_error_out(diag));
    talker_model talker_u (.clk_in(clk_in), .nrfd_wire_in(nrfd_w), .ndac_wire_in(ndac_w),
        .atn_n_out(atn_n), .dav_n_out(dav_n), .data_n_out(data_n), .absent_out(absent),
        .order_bad_out(bad));
    // Address bytes: listen group with an address, talk group never matches.
    function automatic logic [7:0] listen_byte(input logic [4:0] a);
        return {3'h1, a};
    endfunction : listen_byte
    function automatic logic [7:0] talk_byte(input int r);
        return {3'h2, r[4:0]};
    endfunction : talk_byte
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task print_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // About 12 handshakes of some 270 cycles each; this ceiling is generous.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            $display("ERROR timeout expected done seen hung");
            print_verdict();
        end
    end
    // Peripheral latches after a random wait and holds its reply until the strobe drops.
    always @(negedge clk_in) begin
        if (rst_in || !strobe) begin
            got_in <= 1'b0;
        end else if (!got_in) begin
            check("ndac held", 8'h01, {7'h0, ndac_oe});
            if (($random(seed) & 3) == 0) begin
                got_in <= 1'b1;
                grabs++;
                check("grab data", exp_byte, pdata);
            end
        end
    end
    // Foreign addressing, own address, data with a busy stall, then unlisten.
    initial begin
        {rst_in, ce, talk_in, busy_in, exp_byte} = {4'hc, 8'h00};
        addr = 5'($random(seed)) & 5'h0f;
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        check("reset", 8'h00, {3'h0, nrfd_oe, ndac_oe, strobe, lsn, 1'b0});
        check("reset data", 8'h00, pdata);
        talker_u.set_atn(1'b1);
        for (i = 0; i < 3; i++) talker_u.send(talk_byte($random(seed)));
        check("listener", 8'h00, {7'h0, lsn});
        talker_u.set_atn(1'b0);
        check("idle", 8'h00, {6'h0, nrfd_oe, ndac_oe});
        check("absent", 8'h03, {6'h0, absent, diag});
        $display("test foreign done");
        talker_u.set_atn(1'b1);
        talker_u.send(listen_byte(addr));
        check("listener", 8'h01, {7'h0, lsn});
        talker_u.send(talk_byte($random(seed)));
        check("atn data", 8'h00, pdata);
        check("atn grabs", 8'h00, grabs[7:0]);
        talker_u.set_atn(1'b0);
        check("ready", 8'h01, {6'h0, nrfd_oe, ndac_oe});
        check("absent", 8'h00, {7'h0, absent});
        $display("test own address done");
        for (i = 0; i < 6; i++) begin
            exp_byte = 8'($random(seed));
            if (i == 2) begin
                // With the enable low the busy request must not reach NRFD until it returns.
                ce = 1'b0;
                busy_in = 1'b1;
                repeat (6) @(negedge clk_in);
                check("frozen nrfd", 8'h00, {7'h0, nrfd_oe});
                ce = 1'b1;
                repeat (6) @(negedge clk_in);
                check("busy nrfd", 8'h01, {7'h0, nrfd_oe});
                busy_in = 1'b0;
                repeat (6) @(negedge clk_in);
                check("free nrfd", 8'h00, {7'h0, nrfd_oe});
            end
            talker_u.send(exp_byte);
            check("data", exp_byte, pdata);
            repeat (6) @(negedge clk_in);
            check("ready", 8'h01, {6'h0, nrfd_oe, ndac_oe});
        end
        check("grabs", 8'h06, grabs[7:0]);
        $display("test data done");
        talker_u.set_atn(1'b1);
        talker_u.send(8'h3f);
        talker_u.set_atn(1'b0);
        check("unlisten", 8'h00, {5'h0, lsn, nrfd_oe, ndac_oe});
        for (i = 0; i < 2; i++) begin
            talk_in = i[0];
            @(negedge clk_in);
            check("direction", {7'h0, ~i[0]}, {7'h0, rx});
        end
        check("order", 8'h00, {7'h0, bad});
        $display("test unlisten done");
        print_verdict();
    end
endmodule : ieee488_listen_handshake_bench
